//--- rtl/sarc_buf.sv
// Two-entry valid/ready buffer between SAR engine and output latch
`timescale 1ns/1ps
module sarc_buf (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire sarc_pkg::sarc_word_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output sarc_pkg::sarc_word_t out_data
);
  import sarc_pkg::*;

  sarc_word_t mem [2];
  logic wr_idx;
  logic rd_idx;
  logic [1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_idx];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem[0] <= SARC_WORD_ZERO;
      mem[1] <= SARC_WORD_ZERO;
    end else if (ce && push) begin
      mem[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      count <= 2'h0;
    end else if (ce) begin
      if (push) begin
        wr_idx <= ~wr_idx;
      end
      if (pop) begin
        rd_idx <= ~rd_idx;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end

endmodule : sarc_buf

//--- rtl/sarc_pkg.sv
// Shared constants and types of the converter control block
package sarc_pkg;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int SARC_W = 16;
  localparam int SARC_BYTE = 8;
  localparam int SARC_MSB = SARC_W - 1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SARC_CLK_PERIOD_NS = 25;
  // Typical conversion time, taken as the upper bound (floor)
  localparam int SARC_CONV_TIME_NS = 2300;
  localparam int SARC_CONV_CYC = SARC_CONV_TIME_NS / SARC_CLK_PERIOD_NS;
  // Cycles outside bit decisions: clear, handoff, latch, release
  localparam int SARC_OVERHEAD_CYC = 4;
  localparam int SARC_BIT_CYC_I =
    (SARC_CONV_CYC - SARC_OVERHEAD_CYC) / SARC_W;
  localparam int SARC_STEP_W = 4;
  localparam logic [SARC_STEP_W-1:0] SARC_BIT_CYC =
    SARC_BIT_CYC_I[SARC_STEP_W-1:0];
  localparam logic [SARC_STEP_W-1:0] SARC_STEP_ZERO = 4'h0;
  localparam logic [SARC_STEP_W-1:0] SARC_STEP_ONE = 4'h1;

  // Host-side limits, watched and reported only
  localparam int SARC_PULSE_MIN_NS = 40;
  localparam int SARC_RELEASE_MAX_NS = 1000;
  localparam int SARC_ACQ_MIN_NS = 1500;
  localparam int SARC_PULSE_MIN_CYC =
    (SARC_PULSE_MIN_NS + SARC_CLK_PERIOD_NS - 1) / SARC_CLK_PERIOD_NS;
  localparam int SARC_RELEASE_MAX_CYC =
    SARC_RELEASE_MAX_NS / SARC_CLK_PERIOD_NS;
  localparam int SARC_ACQ_MIN_CYC =
    (SARC_ACQ_MIN_NS + SARC_CLK_PERIOD_NS - 1) / SARC_CLK_PERIOD_NS;
  localparam int SARC_TMR_W = 8;
  localparam logic [SARC_TMR_W-1:0] SARC_TMR_ZERO = 8'h00;
  localparam logic [SARC_TMR_W-1:0] SARC_TMR_ONE = 8'h01;
  localparam logic [SARC_TMR_W-1:0] SARC_TMR_MAX = 8'hff;

  // ****************************************************************
  // Reset value and sign-flip mask
  // ****************************************************************
  localparam logic [SARC_W-1:0] SARC_WORD_ZERO = 16'h0000;
  localparam logic [SARC_W-1:0] SARC_SIGN_FLIP = 16'h8000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [SARC_W-1:0] sarc_word_t;

  typedef struct packed {
    logic cs_n;
    logic rc_n;
    logic byte_sel;
  } sarc_host_t;

  typedef struct packed {
    logic pulse_short;
    logic release_late;
    logic acq_short;
  } sarc_warn_t;

endpackage : sarc_pkg

//--- rtl/sarc_sar.sv
// Successive-approximation engine: bit stepping and result handoff
`timescale 1ns/1ps
module sarc_sar (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic cmp_keep,
  output sarc_pkg::sarc_word_t trial,
  output logic hold,
  output logic res_valid,
  input wire logic res_ready,
  output sarc_pkg::sarc_word_t result
);
  import sarc_pkg::*;

  typedef enum logic [1:0] {
    SARC_S_IDLE,
    SARC_S_BIT,
    SARC_S_HAND
  } sarc_sar_st_t;

  sarc_sar_st_t state;
  logic [SARC_STEP_W-1:0] step;
  logic [SARC_STEP_W-1:0] bit_idx;

  assign hold = (state != SARC_S_IDLE);
  assign res_valid = (state == SARC_S_HAND);
  // Offset-binary code flipped at the sign bit gives two's complement
  // two's complement out
  assign result = trial ^ SARC_SIGN_FLIP;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SARC_S_IDLE;
      step <= SARC_STEP_ZERO;
      bit_idx <= SARC_STEP_ZERO;
      trial <= SARC_WORD_ZERO;
    end else if (ce) begin
      case (state)
        SARC_S_IDLE: begin
          if (start) begin
            trial <= SARC_WORD_ZERO;
            trial[SARC_MSB] <= 1'b1;
            bit_idx <= SARC_MSB[SARC_STEP_W-1:0];
            step <= SARC_BIT_CYC;
            state <= SARC_S_BIT;
          end
        end
        SARC_S_BIT: begin
          if (step != SARC_STEP_ONE) begin
            step <= step - SARC_STEP_ONE;
          end else begin
            trial[bit_idx] <= cmp_keep;
            step <= SARC_BIT_CYC;
            if (bit_idx == SARC_STEP_ZERO) begin
              state <= SARC_S_HAND;
            end else begin
              trial[bit_idx - SARC_STEP_ONE] <= 1'b1;
              bit_idx <= bit_idx - SARC_STEP_ONE;
            end
          end
        end
        SARC_S_HAND: begin
          // Stalls here while the buffer is full
          if (res_ready) begin
            state <= SARC_S_IDLE;
          end
        end
        default: begin
          state <= SARC_S_IDLE;
        end
      endcase
    end
  end

endmodule : sarc_sar

//--- rtl/sarc_top.sv
// Conversion control, output latch and parallel bus of the converter
`timescale 1ns/1ps

module sarc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire sarc_pkg::sarc_host_t host,
  input wire logic cmp_keep,
  output sarc_pkg::sarc_word_t data_out,
  output logic data_oe_n,
  output logic busy_n,
  output logic sample_hold,
  output sarc_pkg::sarc_word_t dac_code,
  output sarc_pkg::sarc_warn_t warn
);
  import sarc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum logic [1:0] {
    SARC_T_IDLE,
    SARC_T_CONV,
    SARC_T_LATCH,
    SARC_T_SHOW
  } sarc_top_st_t;

  sarc_top_st_t state;
  logic sel_or;
  logic sel_or_prev;
  logic start_req;
  logic conv_start;
  logic read_en;
  sarc_word_t out_latch;
  sarc_word_t trial;
  logic hold;
  logic res_valid;
  logic res_ready;
  sarc_word_t result;
  logic buf_valid;
  logic buf_ready;
  sarc_word_t buf_data;
  logic latch_load;
  logic [SARC_TMR_W-1:0] pulse_tmr;
  logic [SARC_TMR_W-1:0] conv_tmr;
  logic [SARC_TMR_W-1:0] acq_tmr;
  logic acq_running;

  // ****************************************************************
  // Host strobe decode
  // ****************************************************************
  // OR of both selects
  assign sel_or = host.cs_n | host.rc_n;
  assign start_req = sel_or_prev && !sel_or;
  assign conv_start = start_req && (state == SARC_T_IDLE);
  assign read_en = !host.cs_n && host.rc_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_or_prev <= 1'b1;
    end else if (ce) begin
      sel_or_prev <= sel_or;
    end
  end

  // ****************************************************************
  // Conversion engine and result buffer
  // ****************************************************************
  // bit timing from fixed counts
  sarc_sar u_sarc_sar (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(conv_start),
    .cmp_keep(cmp_keep),
    .trial(trial),
    .hold(hold),
    .res_valid(res_valid),
    .res_ready(res_ready),
    .result(result)
  );

  sarc_buf u_sarc_buf (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(result),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // Latch only changes while the bus is released, so a read in
  // progress never sees a torn word; the buffer absorbs the wait
  assign buf_ready = !read_en;
  assign latch_load = buf_valid && buf_ready;

  // ****************************************************************
  // Output latch
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_latch <= SARC_WORD_ZERO;
    end else if (ce && latch_load) begin
      out_latch <= buf_data;
    end
  end

  // ****************************************************************
  // Conversion sequencing
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SARC_T_IDLE;
    end else if (ce) begin
      case (state)
        SARC_T_IDLE: begin
          if (conv_start) begin
            state <= SARC_T_CONV;
          end
        end
        SARC_T_CONV: begin
          if (res_valid && res_ready) begin
            state <= SARC_T_LATCH;
          end
        end
        SARC_T_LATCH: begin
          if (latch_load) begin
            state <= SARC_T_SHOW;
          end
        end
        SARC_T_SHOW: begin
          state <= SARC_T_IDLE;
        end
        default: begin
          state <= SARC_T_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Busy flag
  // ****************************************************************
  // Rises one edge after the latch loads, together with data_out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_n <= 1'b1;
    end else if (ce) begin
      if (conv_start) begin
        busy_n <= 1'b0;
      end else if (state == SARC_T_SHOW) begin
        busy_n <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Data bus drive
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_oe_n <= 1'b1;
    end else if (ce) begin
      data_oe_n <= !read_en;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= SARC_WORD_ZERO;
    end else if (ce) begin
      if (host.byte_sel) begin
        data_out <= {out_latch[SARC_BYTE-1:0],
                     out_latch[SARC_MSB:SARC_BYTE]};
      end else begin
        data_out <= out_latch;
      end
    end
  end

  // ****************************************************************
  // Analog front-end controls
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_hold <= 1'b0;
      dac_code <= SARC_WORD_ZERO;
    end else if (ce) begin
      // Hold from start until the word has left the engine
      sample_hold <= hold || conv_start;
      dac_code <= trial;
    end
  end

  // ****************************************************************
  // Host timing watch
  // ****************************************************************
  // These flag host misuse; the converter keeps going regardless,
  // since the damage is to accuracy, not to the sequence.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_tmr <= SARC_TMR_ZERO;
    end else if (ce) begin
      if (start_req) begin
        pulse_tmr <= SARC_TMR_ONE;
      end else if (!sel_or && pulse_tmr != SARC_TMR_MAX) begin
        pulse_tmr <= pulse_tmr + SARC_TMR_ONE;
      end else if (sel_or) begin
        pulse_tmr <= SARC_TMR_ZERO;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_tmr <= SARC_TMR_ZERO;
    end else if (ce) begin
      if (conv_start) begin
        conv_tmr <= SARC_TMR_ONE;
      end else if (conv_tmr != SARC_TMR_ZERO && !host.rc_n) begin
        if (conv_tmr != SARC_TMR_MAX) begin
          conv_tmr <= conv_tmr + SARC_TMR_ONE;
        end
      end else begin
        conv_tmr <= SARC_TMR_ZERO;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_tmr <= SARC_TMR_ZERO;
      acq_running <= 1'b0;
    end else if (ce) begin
      if (state == SARC_T_SHOW) begin
        acq_tmr <= SARC_TMR_ZERO;
        acq_running <= 1'b1;
      end else if (conv_start) begin
        acq_running <= 1'b0;
      end else if (acq_running && acq_tmr != SARC_TMR_MAX) begin
        acq_tmr <= acq_tmr + SARC_TMR_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warn <= '0;
    end else if (ce) begin
      if (conv_start) begin
        warn <= '0;
        warn.acq_short <= acq_running &&
          (acq_tmr < SARC_ACQ_MIN_CYC[SARC_TMR_W-1:0]);
      end
      if (pulse_tmr != SARC_TMR_ZERO && sel_or &&
          pulse_tmr < SARC_PULSE_MIN_CYC[SARC_TMR_W-1:0]) begin
        warn.pulse_short <= 1'b1;
      end
      if (conv_tmr > SARC_RELEASE_MAX_CYC[SARC_TMR_W-1:0]) begin
        warn.release_late <= 1'b1;
      end
    end
  end

  // a start on the edge where busy rises is dropped: state is then still SARC_T_SHOW

endmodule : sarc_top

//--- testbench/sarc_cmp_model.sv
// Comparator model standing on the analog side of the converter
`timescale 1ns/1ps
module sarc_cmp_model (
  input wire sarc_pkg::sarc_word_t dac_code,
  input wire sarc_pkg::sarc_word_t level,
  output logic cmp_keep
);
  import sarc_pkg::*;
  // Ideal and instant; a trial at or below the input level is kept
  assign cmp_keep = (dac_code <= level);
endmodule : sarc_cmp_model

//--- testbench/sarc_top_chk.sv
// Port checker of the converter control block
`timescale 1ns/1ps
module sarc_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire sarc_pkg::sarc_host_t host,
  input wire logic cmp_keep,
  input wire sarc_pkg::sarc_word_t data_out,
  input wire logic data_oe_n,
  input wire logic busy_n,
  input wire logic sample_hold,
  input wire sarc_pkg::sarc_word_t dac_code,
  input wire sarc_pkg::sarc_warn_t warn
);
  import sarc_pkg::*;
  logic [7:0] lo_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Saturates so a stuck busy cannot wrap back into range
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt <= 8'h00;
    end else if (busy_n) begin
      lo_cnt <= 8'h00;
    end else if (lo_cnt != 8'hff) begin
      lo_cnt <= lo_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_START:
    assert property (ce && busy_n && $fell(host.cs_n | host.rc_n)
      |=> !busy_n) else $error("start not taken");
  AST_OE_OFF:
    assert property (ce && (host.cs_n || !host.rc_n) |=> data_oe_n)
      else $error("bus driven while not read");
  AST_OE_ON:
    assert property (ce && !host.cs_n && host.rc_n |=> !data_oe_n)
      else $error("bus not driven on read");
  AST_HOLD:
    assert property ($fell(busy_n) |-> sample_hold)
      else $error("no hold at start");
  AST_CLEAR:
    assert property ($fell(busy_n) |=> dac_code == 16'h8000)
      else $error("trial not cleared at start");
  AST_MSB_FIRST:
    assert property ($fell(busy_n) |-> ##[4:12]
      (dac_code[14] && dac_code[13:0] == 14'h0000))
      else $error("second trial is not next bit");
  AST_BUSY_MIN:
    assert property ($rose(busy_n) |-> lo_cnt >= 8'h50)
      else $error("busy released before all bits");
  AST_BUSY_MAX:
    assert property ($fell(busy_n) |-> ##[80:120] busy_n)
      else $error("conversion too long");
  AST_SWAP:
    assert property (busy_n && $changed(host.byte_sel) |-> ##2
      data_out == {$past(data_out[7:0], 2), $past(data_out[15:8], 2)})
      else $error("byte swap not applied");

  COV_START: cover property ($fell(busy_n));
  COV_DONE: cover property ($rose(busy_n));
  COV_SWAPPED_READ: cover property (!data_oe_n && host.byte_sel);
  COV_FROZEN_CONV: cover property (!ce && !busy_n);
endmodule : sarc_top_chk

//--- testbench/tb_sarc_adc_conversion_control.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
bind sarc_top sarc_top_chk u_sarc_top_chk (.clk(clk), .rst_n(rst_n),
  .ce(ce), .host(host), .cmp_keep(cmp_keep), .data_out(data_out),
  .data_oe_n(data_oe_n), .busy_n(busy_n), .sample_hold(sample_hold),
  .dac_code(dac_code), .warn(warn));

module tb_sar_adc_conversion_control;
  import sarc_pkg::*;
  logic clk;
  logic rst_n;
  logic ce;
  sarc_host_t host;
  logic cmp_keep;
  sarc_word_t data_out;
  logic data_oe_n;
  logic busy_n;
  logic sample_hold;
  sarc_word_t dac_code;
  sarc_warn_t warn;
  sarc_word_t level;
  sarc_word_t last;
  int n_errors;
  int comparisons;

  sarc_top u_sarc_top (.clk(clk), .rst_n(rst_n), .ce(ce), .host(host),
    .cmp_keep(cmp_keep), .data_out(data_out), .data_oe_n(data_oe_n),
    .busy_n(busy_n), .sample_hold(sample_hold), .dac_code(dac_code),
    .warn(warn));
  sarc_cmp_model u_sarc_cmp_model (.dac_code(dac_code), .level(level),
    .cmp_keep(cmp_keep));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic chk(input sarc_word_t got, input sarc_word_t exp);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  function automatic sarc_word_t swp(input sarc_word_t w, input logic sel);
    return sel ? {w[7:0], w[15:8]} : w;
  endfunction : swp

  task automatic start_conv(input logic by_cs, input logic keep_cs);
    repeat (60) @(negedge clk);
    if (by_cs) begin
      host.rc_n = 1'b0;
      @(negedge clk);
      chk({14'h0000, busy_n, data_oe_n}, 16'h0003);
      host.cs_n = 1'b0;
    end else begin
      host.cs_n = 1'b0;
      @(negedge clk);
      host.rc_n = 1'b0;
    end
    @(negedge clk);
    chk({14'h0000, busy_n, sample_hold}, 16'h0001);
    @(negedge clk);
    chk({15'h0000, data_oe_n}, 16'h0001);
    // Pulse of two cycles, released well before busy rises
    host.cs_n = ~keep_cs;
    host.rc_n = 1'b1;
  endtask : start_conv

  task automatic wait_done(output int n);
    n = 0;
    while (busy_n !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        n_errors++;
        close_out();
      end
    end
  endtask : wait_done

  task automatic read(input logic sel, input sarc_word_t exp);
    @(negedge clk);
    host.byte_sel = sel;
    host.cs_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({15'h0000, data_oe_n}, 16'h0000);
    chk(data_out, swp(exp, sel));
    host.byte_sel = ~sel;
    repeat (2) @(negedge clk);
    chk(data_out, swp(exp, ~sel));
    host.cs_n = 1'b1;
    repeat (2) @(negedge clk);
    chk({15'h0000, data_oe_n}, 16'h0001);
  endtask : read

  task automatic convert(input sarc_word_t t, input logic by_cs);
    int n;
    level = t;
    start_conv(by_cs, 1'b0);
    wait_done(n);
    chk(16'(n >= 76 && n <= 90), 16'h0001);
    chk({13'h0000, warn}, 16'h0000);
    chk({15'h0000, sample_hold}, 16'h0000);
    chk(data_out, swp(t ^ 16'h8000, host.byte_sel));
    read(by_cs, t ^ 16'h8000);
    last = t ^ 16'h8000;
  endtask : convert

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_codes();
    sarc_word_t tbl [6] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff,
      16'h1234, 16'ha5c3};
    for (int i = 0; i < 6; i++) begin
      convert(tbl[i], i[0]);
    end
  endtask : sc_codes

  // Second start in mid-conversion must change neither time nor result
  task automatic sc_restart();
    int n;
    level = 16'h0f0f;
    start_conv(1'b0, 1'b0);
    repeat (30) @(negedge clk);
    host.cs_n = 1'b0;
    host.rc_n = 1'b0;
    repeat (2) @(negedge clk);
    host.cs_n = 1'b1;
    host.rc_n = 1'b1;
    wait_done(n);
    chk(16'(n + 32 >= 76 && n + 32 <= 90), 16'h0001);
    read(1'b1, 16'h8f0f);
    last = 16'h8f0f;
  endtask : sc_restart

  // Read of the previous word while the next conversion runs
  task automatic sc_read_busy();
    int n;
    level = 16'h00ff;
    start_conv(1'b0, 1'b1);
    repeat (2) @(negedge clk);
    chk({15'h0000, data_oe_n}, 16'h0000);
    chk(data_out, swp(last, host.byte_sel));
    host.cs_n = 1'b1;
    wait_done(n);
    chk(data_out, swp(16'h80ff, host.byte_sel));
  endtask : sc_read_busy

  // Reset in mid-conversion returns bus enable, busy, hold and warnings to idle
  task automatic sc_reset_mid();
    level = 16'h0f0f;
    start_conv(1'b0, 1'b0);
    repeat (20) @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk({13'h0000, data_oe_n, busy_n, sample_hold}, 16'h0006);
    chk({13'h0000, warn}, 16'h0000);
    rst_n = 1'b1;
  endtask : sc_reset_mid

  // Clock enable low mid-conversion stretches it, result intact
  task automatic sc_freeze();
    int n;
    sarc_word_t code;
    level = 16'h4321;
    start_conv(1'b1, 1'b0);
    repeat (10) @(negedge clk);
    ce = 1'b0;
    code = dac_code;
    repeat (20) @(negedge clk);
    chk(dac_code, code);
    chk({15'h0000, busy_n}, 16'h0000);
    ce = 1'b1;
    wait_done(n);
    chk(16'(n + 10 >= 76 && n + 10 <= 90), 16'h0001);
    chk(data_out, swp(16'hc321, host.byte_sel));
    last = 16'hc321;
  endtask : sc_freeze

  // Host misuse is flagged, conversions still complete
  task automatic sc_misuse();
    int n;
    host.cs_n = 1'b0;
    host.rc_n = 1'b0;
    repeat (50) @(negedge clk);
    host.cs_n = 1'b1;
    host.rc_n = 1'b1;
    wait_done(n);
    chk({13'h0000, warn}, 16'h0003);
    chk(data_out, swp(16'h80ff, host.byte_sel));
    repeat (60) @(negedge clk);
    host.cs_n = 1'b0;
    host.rc_n = 1'b0;
    @(negedge clk);
    host.cs_n = 1'b1;
    host.rc_n = 1'b1;
    wait_done(n);
    chk({13'h0000, warn}, 16'h0004);
  endtask : sc_misuse

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    host = 3'b110;
    level = 16'h0000;
    last = 16'h0000;
    n_errors = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({13'h0000, data_oe_n, busy_n, sample_hold}, 16'h0006);
    chk(dac_code | data_out, 16'h0000);
    rst_n = 1'b1;
    sc_codes();
    sc_restart();
    sc_reset_mid();
    sc_freeze();
    sc_read_busy();
    sc_misuse();
    close_out();
  end
endmodule : tb_sar_adc_conversion_control
